/* hdl/scs_pkg.sv */
package scs_pkg;

   // Reset-time source codes held in reset_osc_select
   localparam logic [2:0] RST_HF_64MHZ = 3'h0;  // Internal fast oscillator at top rate
   localparam logic [2:0] RST_EXT_4X   = 3'h2;  // External source through 4x multiplier
   localparam logic [2:0] RST_LF       = 3'h5;  // Internal slow oscillator
   localparam logic [2:0] RST_HF_1MHZ  = 3'h6;  // Internal fast oscillator at lowest rate
   localparam logic [2:0] RST_EXT      = 3'h7;  // External source, no multiplier

   // External mode codes held in ext_osc_mode
   localparam logic [2:0] EXT_CLOCK_LOW_POWER    = 3'h0;  // Logic clock below 500 kHz
   localparam logic [2:0] EXT_CLOCK_MEDIUM_POWER = 3'h1;  // Logic clock 500 kHz to 16 MHz
   localparam logic [2:0] EXT_CLOCK_HIGH_POWER   = 3'h2;  // Logic clock above 16 MHz
   localparam logic [2:0] LOW_POWER_CRYSTAL      = 3'h4;  // 32 kHz crystal
   localparam logic [2:0] MEDIUM_GAIN_CRYSTAL    = 3'h5;  // 500 kHz to 4 MHz crystal
   localparam logic [2:0] HIGH_GAIN_CRYSTAL      = 3'h6;  // Above 4 MHz crystal

   // Fast internal oscillator rate codes: 1,2,4,8,12,16,32,48,64 MHz
   localparam logic [3:0] HF_RATE_1MHZ  = 4'h0;  // Lowest rate
   localparam logic [3:0] HF_RATE_64MHZ = 4'h8;  // Highest legal code

   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 10;     // sys_clk period
   localparam int unsigned OST_EDGES       = 1024;   // Crystal start-up count
   localparam int unsigned HF_SETTLE_NS    = 1000;   // Least settle after rate change
   localparam int unsigned HF_SETTLE_CYC   = (HF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FAIL_SAFE_MONITOR_TIMEOUT_NS = 64000;  // Longest gap between source edges
   localparam int unsigned FAIL_SAFE_MONITOR_TIMEOUT_CYC = FAIL_SAFE_MONITOR_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam logic [1:0]  GAP_CYC         = 2'h2;   // Gap count load; gates stay off four cycles or more

   localparam logic [10:0] OST_LAST    = 11'(OST_EDGES - 1);   // Last start-up count
   localparam logic [6:0]  HF_SETTLE_W = 7'(HF_SETTLE_CYC);    // Settle load value
   localparam logic [3:0]  DIV_RESET   = 4'h0;                 // Divider 1:1 after reset

   // Clock sources; the value is the gate bit index
   typedef enum logic [1:0] {SRC_HF, SRC_LF, SRC_EXT, SRC_EXT4X} scs_src_t;

   // Source selection sequence
   typedef enum logic [1:0] {ST_BOOT, ST_BREAK, ST_WAIT, ST_RUN} scs_state_t;

endpackage

/* hdl/scs_sync_edge.sv */
`timescale 1ns/100ps
module scs_sync_edge
   import scs_pkg::*;
(
   input  wire logic sys_clk,   // System clock
   input  wire logic resetn,    // Async reset, active low
   input  wire logic clk_en,    // Freezes state while low
   input  wire logic pin_in,    // Asynchronous input
   output logic      level,     // Synchronised level
   output logic      rise       // One-cycle pulse on rising edge
);

   // Stage one is read only by stage two
   typedef struct packed {
      logic s1;    // First stage
      logic s2;    // Second stage
      logic s3;    // Edge history
   } scs_sync_t;

   scs_sync_t r_reg;   // Registered state
   scs_sync_t r_next;  // Next state

   // Shift chain
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = pin_in;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
   end

   // State register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   assign level = r_reg.s2;
   assign rise  = r_reg.s2 & ~r_reg.s3;

endmodule // scs_sync_edge

/* hdl/scs_clock_select.sv */
`timescale 1ns/100ps
// Contract
// - Reset source taken from reset_osc_select
// - ext_osc_mode picks the external mode
// - Three logic-clock power modes offered
// - Three crystal gain modes offered
// - Fast oscillator rate set by hf_freq_select
// - Slow oscillator fixed at 31 kHz
// - Software picks internal or external source
// - Write of select and divider requests switch
// - 4x multiplier usable with external source
// - Clock out is system clock over four
// - Logic-clock modes: pin is GPIO or clock out
// - Monitor falls back to internal oscillator
// - No start-up delay in logic-clock modes
// - Stopped clock halts with state kept
// - Crystal start-up counts 1024 input edges
// - Pattern 010 selects external with 4x
// - Rate write clears ready flags until ready
module scs_clock_select
   import scs_pkg::*;
#(
   parameter int unsigned FAIL_SAFE_MONITOR_TIMEOUT = FAIL_SAFE_MONITOR_TIMEOUT_CYC  // Monitor timeout in cycles
)(
   input  wire logic       sys_clk,            // System clock
   input  wire logic       resetn,             // Async reset, active low
   input  wire logic       clk_en,             // Freezes all state while low
   input  wire logic [2:0] reset_osc_select,   // Source after reset
   input  wire logic [2:0] ext_osc_mode,       // External mode
   input  wire logic       clock_out_enable_n, // Clock out enable, active low
   input  wire logic [2:0] new_osc_select,     // Requested source
   input  wire logic [3:0] new_clock_divider,  // Requested divider
   input  wire logic       osc_switch_wr,      // Write strobe for switch request
   input  wire logic [3:0] hf_freq_select,     // Fast oscillator rate code
   input  wire logic       hf_freq_wr,         // Write strobe for rate code
   input  wire logic       wake_pulse,         // Wake from sleep
   input  wire logic       osc_in_pin,         // External clock or crystal input
   input  wire logic       hf_osc_stable,      // Fast oscillator stable, async
   input  wire logic       mf_osc_stable,      // Mid oscillator stable, async
   input  wire logic       gpio_out_data,      // Pin data when used as GPIO
   input  wire logic       gpio_out_en,        // Pin enable when used as GPIO
   output logic [3:0]      src_gate,           // One-hot source gate, index scs_src_t
   output logic            pll_enable,         // 4x multiplier on
   output logic [3:0]      active_div,         // Divider in use
   output logic [2:0]      ext_mode_active,    // External mode latched at boot
   output logic            switch_busy,        // Switch under way
   output logic            ost_done,           // Start-up timer finished
   output logic            fail_safe_monitor_fail,          // External source failed, sticky
   output logic [3:0]      hf_rate_code,       // Applied fast oscillator rate
   output logic            hf_ready_flag,      // Fast oscillator ready
   output logic            mf_ready_flag,      // Mid oscillator ready
   output logic            osc_out_o,          // Second pin output value
   output logic            osc_out_oe          // Second pin output enable
);

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Whole module state
   typedef struct packed {
      scs_state_t  st;        // Sequence state
      scs_src_t    src;       // Active source
      scs_src_t    pend_src;  // Source being switched to
      logic [3:0]  div;       // Active divider
      logic [3:0]  pend_div;  // Divider being switched to
      logic [2:0]  ext_mode;  // Latched external mode
      logic [3:0]  gate;      // Source gates
      logic        pll_en;    // Multiplier enable
      logic        busy;      // Switch pending
      logic [1:0]  gap;       // Dead-time count
      logic [10:0] ost_cnt;   // Start-up edge count
      logic        ost_done;  // Start-up finished
      logic [15:0] fail_safe_monitor_cnt;  // Cycles since last source edge
      logic        fail_safe_monitor_fail; // Failure seen
      logic [3:0]  hf_rate;   // Applied rate
      logic [6:0]  settle;    // Rate settle countdown
      logic        hf_rdy;    // Fast ready
      logic        mf_rdy;    // Mid ready
      logic [1:0]  co_div;    // Clock-out divider
      logic        osc_o;     // Pin value
      logic        osc_oe;    // Pin enable
   } scs_state_s_t;

   scs_state_s_t r_reg;   // Registered state
   scs_state_s_t r_next;  // Next state

   logic osc_rise;     // Source edge, synchronised
   logic hf_sync;      // Fast oscillator stable
   logic mf_sync;      // Mid oscillator stable
   logic xtal;         // Crystal mode latched
   logic pin_used;     // Crystal owns the second pin from boot, start-up included
   logic fail_safe_monitor_hit;     // Monitor timeout this cycle
   logic ost_hit;      // Last start-up edge this cycle
   logic clkout_mode;  // Pin carries clock out

   // Source code to source
   function automatic scs_src_t decode_src(input logic [2:0] code);
      unique case (code)
         RST_EXT_4X: decode_src = SRC_EXT4X;
         RST_EXT:    decode_src = SRC_EXT;
         RST_LF:     decode_src = SRC_LF;
         default:    decode_src = SRC_HF;     // Unused codes land on the safe source
      endcase
   endfunction

   // Crystal modes need the start-up timer
   function automatic logic is_xtal(input logic [2:0] mode);
      is_xtal = (mode == LOW_POWER_CRYSTAL) || (mode == MEDIUM_GAIN_CRYSTAL)
             || (mode == HIGH_GAIN_CRYSTAL);
   endfunction

   // Whether the chosen source can be gated on
   function automatic logic src_ready(input scs_src_t s, input logic hf, input logic crystal_startup_timer);
      unique case (s)
         SRC_HF:  src_ready = hf;
         SRC_LF:  src_ready = 1'b1;
         default: src_ready = crystal_startup_timer;
      endcase
   endfunction

   // Input synchronisers
   scs_sync_edge u_sync_osc (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
                             .pin_in(osc_in_pin), .level(), .rise(osc_rise));
   scs_sync_edge u_sync_hf  (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
                             .pin_in(hf_osc_stable), .level(hf_sync), .rise());
   scs_sync_edge u_sync_mf  (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
                             .pin_in(mf_osc_stable), .level(mf_sync), .rise());

   assign xtal        = is_xtal(r_reg.ext_mode);
   assign pin_used    = (r_reg.st == ST_BOOT) ? is_xtal(ext_osc_mode) : xtal;
   assign clkout_mode = !clock_out_enable_n && !pin_used;
   assign fail_safe_monitor_hit    = (r_reg.st == ST_RUN) && !osc_rise && !r_reg.gate[SRC_HF]
                     && !r_reg.gate[SRC_LF] && (r_reg.fail_safe_monitor_cnt == 16'(FAIL_SAFE_MONITOR_TIMEOUT - 1));
   assign ost_hit     = xtal && !r_reg.ost_done && osc_rise && (r_reg.ost_cnt == OST_LAST);

   // Next-state logic
   always_comb begin
      r_next        = r_reg;
      r_next.co_div = r_reg.co_div + 2'h1;

      // Start-up timer, restarted at boot and on wake
      if (r_reg.st == ST_BOOT || wake_pulse) begin
         r_next.ost_cnt  = '0;
         r_next.ost_done = (r_reg.st == ST_BOOT) ? !is_xtal(ext_osc_mode) : !xtal;
      end else if (ost_hit) begin
         r_next.ost_done = 1'b1;
      end else if (xtal && !r_reg.ost_done && osc_rise) begin
         r_next.ost_cnt = r_reg.ost_cnt + 11'h001;
      end

      // Rate change; the clear wins over a ready in the same cycle
      if (hf_freq_wr && hf_freq_select <= HF_RATE_64MHZ) begin
         r_next.hf_rate = hf_freq_select;
         r_next.hf_rdy  = 1'b0;
         r_next.mf_rdy  = 1'b0;
         r_next.settle  = HF_SETTLE_W;
      end else if (r_reg.settle != '0) begin
         r_next.settle = r_reg.settle - 7'h01;
      end else begin
         if (hf_sync) r_next.hf_rdy = 1'b1;
         if (mf_sync) r_next.mf_rdy = 1'b1;
      end

      // Monitor counts idle cycles of the external source
      if (r_reg.st == ST_RUN && !r_reg.gate[SRC_HF] && !r_reg.gate[SRC_LF] && !osc_rise) begin
         r_next.fail_safe_monitor_cnt = r_reg.fail_safe_monitor_cnt + 16'h0001;
      end else begin
         r_next.fail_safe_monitor_cnt = '0;
      end

      // Source sequence: all gates off for a gap before the new one opens
      unique case (r_reg.st)
         ST_BOOT: begin
            r_next.pend_src = decode_src(reset_osc_select);
            r_next.pend_div = DIV_RESET;
            r_next.ext_mode = ext_osc_mode;
            if (reset_osc_select == RST_HF_1MHZ) r_next.hf_rate = HF_RATE_1MHZ;
            if (reset_osc_select == RST_HF_64MHZ) r_next.hf_rate = HF_RATE_64MHZ;
            r_next.busy = 1'b1;
            r_next.st   = ST_WAIT;
         end
         ST_BREAK: begin
            if (r_reg.gap != '0) begin
               r_next.gap = r_reg.gap - 2'h1;
            end else begin
               r_next.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (src_ready(r_reg.pend_src, r_reg.hf_rdy, r_reg.ost_done)) begin
               r_next.src  = r_reg.pend_src;
               r_next.div  = r_reg.pend_div;
               r_next.gate = 4'h1 << r_reg.pend_src;
               r_next.pll_en = (r_reg.pend_src == SRC_EXT4X);
               r_next.busy = 1'b0;
               r_next.st   = ST_RUN;
            end
         end
         ST_RUN: begin
            if (fail_safe_monitor_hit) begin
               r_next.fail_safe_monitor_fail = 1'b1;
               r_next.pend_src  = SRC_HF;
               r_next.pend_div  = DIV_RESET;
            end else if (osc_switch_wr) begin
               r_next.pend_src = decode_src(new_osc_select);
               r_next.pend_div = new_clock_divider;
            end
            if (fail_safe_monitor_hit || osc_switch_wr) begin
               r_next.gate   = '0;
               r_next.pll_en = 1'b0;
               r_next.gap    = GAP_CYC;
               r_next.busy   = 1'b1;
               r_next.st     = ST_BREAK;
            end
         end
      endcase

      // Second pin: clock out, GPIO, or left to the crystal
      if (clkout_mode) begin
         r_next.osc_o  = r_next.co_div[1];
         r_next.osc_oe = 1'b1;
      end else if (pin_used) begin
         r_next.osc_o  = 1'b0;
         r_next.osc_oe = 1'b0;
      end else begin
         r_next.osc_o  = gpio_out_data;
         r_next.osc_oe = gpio_out_en;
      end
   end

   // State register; a low enable holds everything as a stopped clock would
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r_reg          <= '0;
         r_reg.st       <= ST_BOOT;
         r_reg.settle   <= HF_SETTLE_W;
         r_reg.pend_src <= SRC_HF;
         r_reg.src      <= SRC_HF;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   assign src_gate        = r_reg.gate;
   assign pll_enable      = r_reg.pll_en;
   assign active_div      = r_reg.div;
   assign ext_mode_active = r_reg.ext_mode;
   assign switch_busy     = r_reg.busy;
   assign ost_done        = r_reg.ost_done;
   assign fail_safe_monitor_fail       = r_reg.fail_safe_monitor_fail;
   assign hf_rate_code    = r_reg.hf_rate;
   assign hf_ready_flag   = r_reg.hf_rdy;
   assign mf_ready_flag   = r_reg.mf_rdy;
   assign osc_out_o       = r_reg.osc_o;
   assign osc_out_oe      = r_reg.osc_oe;

   // Checks
   AST_BOOT_SRC: assert property (
      clk_en && r_reg.st == ST_BOOT |=> r_reg.pend_src == decode_src($past(reset_osc_select)))
      else $error("Boot source does not follow reset_osc_select");
   AST_EC_NO_OST: assert property (
      clk_en && r_reg.st == ST_BOOT && !is_xtal(ext_osc_mode) |=> r_reg.ost_done)
      else $error("Start-up delay in logic-clock mode");
   AST_OST_LAST: assert property (
      clk_en && r_reg.st != ST_BOOT && !wake_pulse && xtal && !r_reg.ost_done
      && $rose(r_next.ost_done) |-> r_reg.ost_cnt == OST_LAST && osc_rise)
      else $error("Start-up ended before 1024 edges");
   AST_PLL_GATE: assert property (
      r_reg.gate[SRC_EXT4X] |-> r_reg.pll_en && r_reg.src == SRC_EXT4X)
      else $error("Multiplier path gated without multiplier");
   AST_ONEHOT: assert property (
      $onehot0(r_reg.gate))
      else $error("Two sources gated at once");
   AST_BREAK: assert property (
      clk_en && r_reg.st == ST_RUN && osc_switch_wr |=> (r_reg.gate == 4'h0)[*4])
      else $error("Gate dead time too short");
   AST_FAIL_SAFE_MONITOR: assert property (
      clk_en && fail_safe_monitor_hit |=> r_reg.fail_safe_monitor_fail && r_reg.pend_src == SRC_HF && r_reg.gate == 4'h0)
      else $error("Monitor failed to fall back");
   AST_HF_CLEAR: assert property (
      clk_en && hf_freq_wr && hf_freq_select <= HF_RATE_64MHZ
      |=> !r_reg.hf_rdy && !r_reg.mf_rdy && r_reg.hf_rate == $past(hf_freq_select))
      else $error("Ready flags not cleared on rate write");
   AST_CLKOUT: assert property (
      clk_en && clkout_mode |=> r_reg.osc_oe && r_reg.osc_o == r_reg.co_div[1])
      else $error("Clock out not system clock over four");
   AST_FREEZE: assert property (
      !clk_en |=> $stable(r_reg))
      else $error("State moved while clock enable low");
   AST_TAKE: assert property (
      clk_en && r_reg.st == ST_WAIT && src_ready(r_reg.pend_src, r_reg.hf_rdy, r_reg.ost_done)
      |=> r_reg.src == $past(r_reg.pend_src) && r_reg.div == $past(r_reg.pend_div)
      && !r_reg.busy)
      else $error("Requested source or divider not applied");

endmodule // scs_clock_select

/* tb/scs_ext_osc.sv */
`timescale 1ns/100ps
// External logic clock or crystal, as seen at the input pin
module scs_ext_osc
#(
   parameter int HALF_NS = 15  // Half period; kept above one system clock for the synchroniser
)(
   input  wire logic run,      // Oscillation on while high
   output logic      osc_pin   // Pin level
);
   // A stopped source parks low, so the monitor sees no rising edges
   initial osc_pin = 1'b0;

   // Free toggle while enabled
   always begin
      #(HALF_NS);
      osc_pin = run ? ~osc_pin : 1'b0;
   end
endmodule // scs_ext_osc

/* tb/test_system_clock_source_select.sv */
`timescale 1ns/100ps
module test_system_clock_source_select
   import scs_pkg::*;
;
   logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;  // Clock, reset, freeze
   logic [2:0] reset_osc_select = RST_HF_64MHZ, ext_osc_mode = EXT_CLOCK_MEDIUM_POWER;
   logic [2:0] new_osc_select = 3'h0;                    // Requested source
   logic [3:0] new_clock_divider = 4'h0, hf_freq_select = 4'h0;
   logic osc_switch_wr = 1'b0, hf_freq_wr = 1'b0, wake_pulse = 1'b0;  // Strobes
   logic clock_out_enable_n = 1'b1, osc_run = 1'b1;      // Pin config, oscillator run
   logic hf_osc_stable = 1'b1, mf_osc_stable = 1'b1;     // Oscillator stable inputs
   logic gpio_out_data = 1'b0, gpio_out_en = 1'b0;       // GPIO side of second pin
   logic osc_in_pin, pll_enable, switch_busy, ost_done, fail_safe_monitor_fail;
   logic hf_ready_flag, mf_ready_flag, osc_out_o, osc_out_oe;
   logic [3:0] src_gate, active_div, hf_rate_code;
   logic [2:0] ext_mode_active;
   int failures = 0, checks_done = 0;                    // Result counters
   logic [2:0] bc[5] = '{RST_HF_64MHZ, RST_EXT_4X, RST_LF, RST_HF_1MHZ, RST_EXT};
   logic [3:0] bg[5] = '{4'h1, 4'h8, 4'h2, 4'h1, 4'h4}; // Gate expected per boot code
   logic [2:0] sw[3] = '{3'h5, 3'h7, 3'h6};              // Run-time switch targets
   logic [3:0] sg[3] = '{4'h2, 4'h4, 4'h1};              // Gate expected per target
   logic [2:0] md[6] = '{EXT_CLOCK_LOW_POWER, EXT_CLOCK_MEDIUM_POWER, EXT_CLOCK_HIGH_POWER,
                         LOW_POWER_CRYSTAL, MEDIUM_GAIN_CRYSTAL, HIGH_GAIN_CRYSTAL};
   logic smp[6];                                         // Clock-out samples
   logic [3:0] held_gate;                                // Gate seen before freeze

   // Short monitor timeout keeps the fail-safe run brief
   scs_clock_select #(.FAIL_SAFE_MONITOR_TIMEOUT(20)) dut (
      .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
      .reset_osc_select(reset_osc_select), .ext_osc_mode(ext_osc_mode),
      .clock_out_enable_n(clock_out_enable_n), .new_osc_select(new_osc_select),
      .new_clock_divider(new_clock_divider), .osc_switch_wr(osc_switch_wr),
      .hf_freq_select(hf_freq_select), .hf_freq_wr(hf_freq_wr), .wake_pulse(wake_pulse),
      .osc_in_pin(osc_in_pin), .hf_osc_stable(hf_osc_stable), .mf_osc_stable(mf_osc_stable),
      .gpio_out_data(gpio_out_data), .gpio_out_en(gpio_out_en), .src_gate(src_gate),
      .pll_enable(pll_enable), .active_div(active_div), .ext_mode_active(ext_mode_active),
      .switch_busy(switch_busy), .ost_done(ost_done), .fail_safe_monitor_fail(fail_safe_monitor_fail),
      .hf_rate_code(hf_rate_code), .hf_ready_flag(hf_ready_flag),
      .mf_ready_flag(mf_ready_flag), .osc_out_o(osc_out_o), .osc_out_oe(osc_out_oe));

   // External source on the input pin; 16 ns keeps its edges off sys_clk rising edges
   scs_ext_osc #(.HALF_NS(16)) osc (.run(osc_run), .osc_pin(osc_in_pin));

   // 100 MHz system clock
   always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   // Count and report one mismatch
   task automatic fail(input string msg);
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask

   // Single-bit result
   task automatic chk1(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) fail(what);
   endtask

   // Multi-bit result, narrower fields zero-extended
   task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
      checks_done++;
      if (got !== exp) fail(what);
   endtask

   // Verdict and end of run
   task automatic results();
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Bounded wait: 0 busy low, 1 fast ready set, 2 monitor tripped, 3 start-up done
   task automatic wait_until(input int which, input int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         @(negedge sys_clk);
         if (which == 0 && switch_busy === 1'b0) break;
         if (which == 1 && hf_ready_flag === 1'b1) break;
         if (which == 2 && fail_safe_monitor_fail === 1'b1) break;
         if (which == 3 && ost_done === 1'b1) break;
      end
      if (i == bound) begin
         fail("wait ran out");
         results();
      end
   endtask

   // Reset with new configuration; ends once boot has begun
   task automatic boot(input logic [2:0] rsel, input logic [2:0] mode);
      @(posedge sys_clk);
      resetn           <= 1'b0;
      reset_osc_select <= rsel;
      ext_osc_mode     <= mode;
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (2) @(negedge sys_clk);
   endtask

   // One-cycle switch request
   task automatic request(input logic [2:0] sel, input logic [3:0] div);
      @(posedge sys_clk);
      new_osc_select    <= sel;
      new_clock_divider <= div;
      osc_switch_wr     <= 1'b1;
      @(posedge sys_clk);
      osc_switch_wr <= 1'b0;
   endtask

   // One-cycle rate write
   task automatic rate_write(input logic [3:0] code);
      @(posedge sys_clk);
      hf_freq_select <= code;
      hf_freq_wr     <= 1'b1;
      @(posedge sys_clk);
      hf_freq_wr <= 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   initial begin
      // Every boot code, external mode held at medium power
      for (int i = 0; i < 5; i++) begin
         boot(bc[i], EXT_CLOCK_MEDIUM_POWER);
         wait_until(0, 300);
         chk4(src_gate, bg[i], "boot gate");
         chk1(pll_enable, bc[i] == RST_EXT_4X, "boot pll");
         chk4(hf_rate_code, bc[i] == RST_HF_64MHZ ? HF_RATE_64MHZ : HF_RATE_1MHZ, "rate");
      end
      $display("test boot_sources done");
      // Switch to 4x; a second request while busy must be dropped
      boot(RST_HF_64MHZ, EXT_CLOCK_MEDIUM_POWER);
      wait_until(0, 300);
      request(3'h2, 4'h3);
      request(3'h5, 4'h0);
      @(negedge sys_clk);
      chk4(src_gate, 4'h0, "gate during gap");
      chk1(switch_busy, 1'b1, "busy during switch");
      wait_until(0, 400);
      chk4(src_gate, 4'h8, "gate after 4x switch");
      chk1(pll_enable, 1'b1, "pll after switch");
      chk4(active_div, 4'h3, "divider after switch");
      for (int i = 0; i < 3; i++) begin
         request(sw[i], 4'(i));
         repeat (2) @(negedge sys_clk);
         chk4(src_gate, 4'h0, "no overlap of gates");
         wait_until(0, 400);
         chk4(src_gate, sg[i], "switched gate");
         chk4(active_div, 4'(i), "switched divider");
      end
      $display("test run_switch done");
      // Rate change clears both ready flags until settled
      rate_write(4'h3);
      chk4(hf_rate_code, 4'h3, "new rate");
      chk1(hf_ready_flag, 1'b0, "fast ready cleared");
      chk1(mf_ready_flag, 1'b0, "mid ready cleared");
      @(posedge sys_clk);
      mf_osc_stable <= 1'b0;
      repeat (50) @(negedge sys_clk);
      chk1(hf_ready_flag, 1'b0, "fast ready early");
      wait_until(1, 120);
      chk1(mf_ready_flag, 1'b0, "mid waits for its oscillator");
      @(posedge sys_clk);
      mf_osc_stable <= 1'b1;
      repeat (4) @(negedge sys_clk);
      chk1(mf_ready_flag, 1'b1, "mid ready set");
      rate_write(4'h9);
      chk4(hf_rate_code, 4'h3, "illegal rate ignored");
      $display("test rate_write done");
      // Clock out runs at one quarter of the system clock
      @(posedge sys_clk);
      clock_out_enable_n <= 1'b0;
      repeat (3) @(negedge sys_clk);
      chk1(osc_out_oe, 1'b1, "clock out drives");
      for (int i = 0; i < 6; i++) begin
         @(negedge sys_clk);
         smp[i] = osc_out_o;
      end
      for (int i = 0; i < 4; i++) chk1(smp[i + 2], ~smp[i], "clock out period");
      @(posedge sys_clk);
      clock_out_enable_n <= 1'b1;
      gpio_out_en        <= 1'b1;
      gpio_out_data      <= 1'b1;
      repeat (3) @(negedge sys_clk);
      chk1(osc_out_oe, 1'b1, "gpio enable");
      chk1(osc_out_o, 1'b1, "gpio data");
      $display("test clock_out done");
      // Stopped clock: nothing moves, gpio change not copied
      @(posedge sys_clk);
      clk_en <= 1'b0;
      @(negedge sys_clk);
      held_gate = src_gate;
      @(posedge sys_clk);
      gpio_out_data <= 1'b0;
      repeat (20) @(negedge sys_clk);
      chk1(osc_out_o, 1'b1, "frozen pin");
      chk4(src_gate, held_gate, "frozen gate");
      @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (3) @(negedge sys_clk);
      chk1(osc_out_o, 1'b0, "resumed pin");
      $display("test freeze done");
      // Every external mode; crystals wait for the start-up count
      @(posedge sys_clk);
      clock_out_enable_n <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         boot(RST_EXT, md[i]);
         if (md[i][2]) begin
            repeat (1000) @(negedge sys_clk);
            chk1(switch_busy, 1'b1, "crystal still starting");
            wait_until(0, 4000);
            chk1(ost_done, 1'b1, "start-up done");
         end else begin
            wait_until(0, 10);
         end
         chk4(src_gate, 4'h4, "external gate");
         chk4({1'b0, ext_mode_active}, {1'b0, md[i]}, "mode latched");
         chk1(osc_out_oe, ~md[i][2], "pin owner");
      end
      $display("test ext_modes done");
      // Wake restarts the crystal count while the source stays gated
      @(posedge sys_clk);
      wake_pulse <= 1'b1;
      @(posedge sys_clk);
      wake_pulse <= 1'b0;
      repeat (1000) @(negedge sys_clk);
      chk1(ost_done, 1'b0, "start-up restarted on wake");
      wait_until(3, 4000);
      chk1(ost_done, 1'b1, "start-up done after wake");
      $display("test wake done");
      // Source dies: monitor falls back to the fast internal oscillator
      boot(RST_EXT, EXT_CLOCK_HIGH_POWER);
      wait_until(0, 10);
      @(posedge sys_clk);
      osc_run <= 1'b0;
      wait_until(2, 80);
      wait_until(0, 400);
      chk4(src_gate, 4'h1, "fallback gate");
      chk4(active_div, DIV_RESET, "fallback divider");
      chk1(fail_safe_monitor_fail, 1'b1, "monitor flag sticky");
      $display("test fail_safe done");
      results();
   end
endmodule // test_system_clock_source_select
